// ==== pin_routing_pkg.sv ====
package pin_routing_pkg;

	localparam int PORT_W = 8;
	localparam int MOD_W = 6;
	localparam int SENSE_W = 3;
	localparam int FAULT_W = 4;
	localparam int TCH_W = 4;

	// port S bit positions
	localparam int S_SELECT = 7;
	localparam int S_CLOCK = 6;
	localparam int S_MOSI = 5;
	localparam int S_MISO = 4;
	localparam int S_U1_TX = 3;
	localparam int S_U1_RX = 2;
	localparam int S_U0_TX = 1;
	localparam int S_U0_RX = 0;

	// port Q field positions
	localparam int Q_SENSE_LO = 4;
	localparam int Q_FAULT_LO = 0;

	// port T and U field positions
	localparam int T_UPPER_LO = 4;
	localparam int T_LOWER_LO = 0;
	localparam int U_MID_LO = 4;
	localparam int U_MID_W = 2;
	localparam int U_LOW_LO = 0;

	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [2:0] SENSE_IDLE = 3'h7;
	// spi and uart receive inputs idle high while unclaimed
	localparam logic [5:0] SERIAL_IDLE = 6'h3F;

	// general-purpose settings of one port
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
	} gpio_cfg_t;

	// pad drive of one port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pad_drive_t;

	// one timer group of four channels
	typedef struct packed {
		logic enable;
		logic [3:0] pin_en;
		logic [3:0] out;
		logic [3:0] oe;
	} timer_io_t;

endpackage

// ==== peripheral_pin_routing.sv ====
`timescale 1ns/1ns

// Behaviour
// RULE_01: with the fault-protected modulator on, port P bits 5..0 are handed to it whole or pair by pair.
// RULE_02: with the modulator on, port Q bits 6..4 feed its three active-low current-sense inputs.
// RULE_03: with the modulator on, port Q bits 3..0 feed its four fault inputs.
// RULE_04: with the SPI on, port S bit 7 carries slave select and bit 6 the serial clock.
// RULE_05: with the SPI on, port S bit 5 is MOSI and bit 4 MISO, direction following master or slave mode.
// RULE_06: port S bits 3 and 2 become uart one transmit and receive, each on its own enable.
// RULE_07: port S bits 1 and 0 become uart zero transmit and receive, each on its own enable.
// RULE_08: with the second timer on, port T bits 7..4 may serve its channels 7..4.
// RULE_09: with the first timer on, port T bits 3..0 may serve its channels 7..4.
// RULE_10: with the basic modulator on, port U bits 5 and 4 may be its outputs, singly or as a pair.
// RULE_11: port U bits 3..0 go to the third timer or the basic modulator as the routing select says.
// RULE_12: every pin is a high-impedance input during reset and right after it.
// RULE_13: port U bits 7 and 6 are general-purpose only.
// RULE_14: unclaimed pins follow their general-purpose settings; a claim lasts only while enabled.
module peripheral_pin_routing (
	input wire logic core_clk,
	input wire logic reset,
	input wire pin_routing_pkg::gpio_cfg_t gpio_p,
	input wire pin_routing_pkg::gpio_cfg_t gpio_q,
	input wire pin_routing_pkg::gpio_cfg_t gpio_s,
	input wire pin_routing_pkg::gpio_cfg_t gpio_t,
	input wire pin_routing_pkg::gpio_cfg_t gpio_u,
	input wire logic [7:0] pad_in_p,
	input wire logic [7:0] pad_in_q,
	input wire logic [7:0] pad_in_s,
	input wire logic [7:0] pad_in_t,
	input wire logic [7:0] pad_in_u,
	input wire logic fault_protected_modulator_en,
	input wire logic [2:0] modulator_pair_en,
	input wire logic [5:0] fault_modulator_outputs,
	input wire logic sense_en,
	input wire logic fault_en,
	input wire logic spi_en,
	input wire logic spi_master,
	input wire logic spi_select_out,
	input wire logic spi_select_oe,
	input wire logic spi_clock_out,
	input wire logic spi_mosi_out,
	input wire logic spi_miso_out,
	input wire logic uart_one_tx_en,
	input wire logic uart_one_rx_en,
	input wire logic uart_one_transmit,
	input wire logic uart_zero_tx_en,
	input wire logic uart_zero_rx_en,
	input wire logic uart_zero_transmit,
	input wire pin_routing_pkg::timer_io_t first_timer,
	input wire pin_routing_pkg::timer_io_t second_timer,
	input wire pin_routing_pkg::timer_io_t third_timer,
	input wire logic basic_modulator_en,
	input wire logic [5:0] basic_pin_en,
	input wire logic [5:0] basic_modulator_outputs,
	input wire logic [3:0] pin_routing_select,
	output pin_routing_pkg::pad_drive_t drive_p,
	output pin_routing_pkg::pad_drive_t drive_q,
	output pin_routing_pkg::pad_drive_t drive_s,
	output pin_routing_pkg::pad_drive_t drive_t,
	output pin_routing_pkg::pad_drive_t drive_u,
	output logic [7:0] port_read_p,
	output logic [7:0] port_read_q,
	output logic [7:0] port_read_s,
	output logic [7:0] port_read_t,
	output logic [7:0] port_read_u,
	output logic [2:0] current_sense_inputs,
	output logic [3:0] fault_inputs,
	output logic spi_select_in,
	output logic spi_clock_in,
	output logic spi_mosi_in,
	output logic spi_miso_in,
	output logic uart_one_receive,
	output logic uart_zero_receive,
	output logic [3:0] first_timer_channels,
	output logic [3:0] second_timer_channels,
	output logic [3:0] third_timer_channels
);

	localparam int NP = 5;

	// three-stage pad synchronisers; stage 1 is read only by stage 2
	logic [NP-1:0][7:0] sync1_q, sync2_q, sync3_q, clean_q;
	logic [NP-1:0][7:0] sync1_d, sync2_d, sync3_d, clean_d;
	logic [NP-1:0][7:0] pad_in;
	pin_routing_pkg::gpio_cfg_t [NP-1:0] cfg;
	pin_routing_pkg::pad_drive_t [NP-1:0] drive_q_r, drive_d;

	assign pad_in = {pad_in_u, pad_in_t, pad_in_s, pad_in_q, pad_in_p};
	assign cfg = {gpio_u, gpio_t, gpio_s, gpio_q, gpio_p};

	always_comb begin
		sync1_d = pad_in;
		sync2_d = sync1_q;
		sync3_d = sync2_q;
		clean_d = clean_q;
		for (int p = 0; p < NP; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (sync2_q[p][b] == sync3_q[p][b]) begin
					clean_d[p][b] = sync3_q[p][b];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			clean_q <= '0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			sync3_q <= sync3_d;
			clean_q <= clean_d;
		end
	end

	// pad drive: general-purpose first, then peripheral claims
	logic [5:0] mod_claim;

	always_comb begin
		for (int p = 0; p < NP; p++) begin
			drive_d[p].out = cfg[p].data; // see RULE_14
			drive_d[p].oe = cfg[p].dir; // see RULE_13
		end
		for (int i = 0; i < pin_routing_pkg::MOD_W; i++) begin
			mod_claim[i] = fault_protected_modulator_en
				& modulator_pair_en[i/2];
			if (mod_claim[i]) begin
				drive_d[0].out[i] = fault_modulator_outputs[i]; // see RULE_01
				drive_d[0].oe[i] = 1'b1;
			end
		end
		if (fault_protected_modulator_en && sense_en) begin
			drive_d[1].oe[pin_routing_pkg::Q_SENSE_LO +: 3] = '0; // see RULE_02
		end
		if (fault_protected_modulator_en && fault_en) begin
			drive_d[1].oe[pin_routing_pkg::Q_FAULT_LO +: 4] = '0; // see RULE_03
		end
		if (spi_en) begin
			drive_d[2].out[pin_routing_pkg::S_SELECT] = spi_select_out;
			drive_d[2].oe[pin_routing_pkg::S_SELECT] = spi_master
				& spi_select_oe; // see RULE_04
			drive_d[2].out[pin_routing_pkg::S_CLOCK] = spi_clock_out;
			drive_d[2].oe[pin_routing_pkg::S_CLOCK] = spi_master; // see RULE_04
			drive_d[2].out[pin_routing_pkg::S_MOSI] = spi_mosi_out;
			drive_d[2].oe[pin_routing_pkg::S_MOSI] = spi_master; // see RULE_05
			drive_d[2].out[pin_routing_pkg::S_MISO] = spi_miso_out;
			drive_d[2].oe[pin_routing_pkg::S_MISO] = ~spi_master; // see RULE_05
		end
		if (uart_one_tx_en) begin
			drive_d[2].out[pin_routing_pkg::S_U1_TX] = uart_one_transmit; // see RULE_06
			drive_d[2].oe[pin_routing_pkg::S_U1_TX] = 1'b1;
		end
		if (uart_one_rx_en) begin
			drive_d[2].oe[pin_routing_pkg::S_U1_RX] = 1'b0; // see RULE_06
		end
		if (uart_zero_tx_en) begin
			drive_d[2].out[pin_routing_pkg::S_U0_TX] = uart_zero_transmit; // see RULE_07
			drive_d[2].oe[pin_routing_pkg::S_U0_TX] = 1'b1;
		end
		if (uart_zero_rx_en) begin
			drive_d[2].oe[pin_routing_pkg::S_U0_RX] = 1'b0; // see RULE_07
		end
		for (int c = 0; c < pin_routing_pkg::TCH_W; c++) begin
			if (second_timer.enable && second_timer.pin_en[c]) begin
				drive_d[3].out[pin_routing_pkg::T_UPPER_LO + c] =
					second_timer.out[c]; // see RULE_08
				drive_d[3].oe[pin_routing_pkg::T_UPPER_LO + c] =
					second_timer.oe[c];
			end
			if (first_timer.enable && first_timer.pin_en[c]) begin
				drive_d[3].out[pin_routing_pkg::T_LOWER_LO + c] =
					first_timer.out[c]; // see RULE_09
				drive_d[3].oe[pin_routing_pkg::T_LOWER_LO + c] =
					first_timer.oe[c];
			end
		end
		for (int c = 0; c < pin_routing_pkg::U_MID_W; c++) begin
			if (basic_modulator_en
				&& basic_pin_en[pin_routing_pkg::U_MID_LO + c]) begin
				drive_d[4].out[pin_routing_pkg::U_MID_LO + c] = // see RULE_10
					basic_modulator_outputs[pin_routing_pkg::U_MID_LO + c];
				drive_d[4].oe[pin_routing_pkg::U_MID_LO + c] = 1'b1;
			end
		end
		for (int c = 0; c < pin_routing_pkg::TCH_W; c++) begin
			if (pin_routing_select[c]) begin
				if (basic_modulator_en && basic_pin_en[c]) begin
					drive_d[4].out[c] = basic_modulator_outputs[c]; // see RULE_11
					drive_d[4].oe[c] = 1'b1;
				end
			end else if (third_timer.enable && third_timer.pin_en[c]) begin
				drive_d[4].out[c] = third_timer.out[c]; // see RULE_11
				drive_d[4].oe[c] = third_timer.oe[c];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			drive_q_r <= '0; // see RULE_12
		end else begin
			drive_q_r <= drive_d;
		end
	end

	assign drive_p = drive_q_r[0];
	assign drive_q = drive_q_r[1];
	assign drive_s = drive_q_r[2];
	assign drive_t = drive_q_r[3];
	assign drive_u = drive_q_r[4];
	assign port_read_p = clean_q[0];
	assign port_read_q = clean_q[1];
	assign port_read_s = clean_q[2];
	assign port_read_t = clean_q[3];
	assign port_read_u = clean_q[4];

	// peripheral inputs; idle values while unclaimed
	logic [2:0] sense_q, sense_d;
	logic [3:0] fault_q, fault_d;
	logic [5:0] spi_uart_q, spi_uart_d;
	logic [3:0] t1_q, t1_d, t2_q, t2_d, t3_q, t3_d;

	always_comb begin
		sense_d = pin_routing_pkg::SENSE_IDLE;
		if (fault_protected_modulator_en && sense_en) begin
			sense_d = clean_q[1][pin_routing_pkg::Q_SENSE_LO +: 3]; // see RULE_02
		end
		fault_d = '0;
		if (fault_protected_modulator_en && fault_en) begin
			fault_d = clean_q[1][pin_routing_pkg::Q_FAULT_LO +: 4]; // see RULE_03
		end
		spi_uart_d = pin_routing_pkg::SERIAL_IDLE;
		if (spi_en) begin
			spi_uart_d[3:0] = clean_q[2][pin_routing_pkg::S_MISO +: 4];
		end
		if (uart_one_rx_en) begin
			spi_uart_d[4] = clean_q[2][pin_routing_pkg::S_U1_RX]; // see RULE_06
		end
		if (uart_zero_rx_en) begin
			spi_uart_d[5] = clean_q[2][pin_routing_pkg::S_U0_RX]; // see RULE_07
		end
		t2_d = second_timer.enable ?
			clean_q[3][pin_routing_pkg::T_UPPER_LO +: 4] : 4'h0; // see RULE_08
		t1_d = first_timer.enable ?
			clean_q[3][pin_routing_pkg::T_LOWER_LO +: 4] : 4'h0; // see RULE_09
		t3_d = third_timer.enable ?
			(clean_q[4][pin_routing_pkg::U_LOW_LO +: 4] & ~pin_routing_select)
			: 4'h0; // see RULE_11
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sense_q <= pin_routing_pkg::SENSE_IDLE;
			fault_q <= '0;
			spi_uart_q <= pin_routing_pkg::SERIAL_IDLE;
			t1_q <= '0;
			t2_q <= '0;
			t3_q <= '0;
		end else begin
			sense_q <= sense_d;
			fault_q <= fault_d;
			spi_uart_q <= spi_uart_d;
			t1_q <= t1_d;
			t2_q <= t2_d;
			t3_q <= t3_d;
		end
	end

	assign current_sense_inputs = sense_q;
	assign fault_inputs = fault_q;
	assign spi_miso_in = spi_uart_q[0];
	assign spi_mosi_in = spi_uart_q[1];
	assign spi_clock_in = spi_uart_q[2];
	assign spi_select_in = spi_uart_q[3];
	assign uart_one_receive = spi_uart_q[4];
	assign uart_zero_receive = spi_uart_q[5];
	assign first_timer_channels = t1_q;
	assign second_timer_channels = t2_q;
	assign third_timer_channels = t3_q;

endmodule

// ==== pad_model.sv ====
`timescale 1ns/1ns
module pad_model (
	input wire pin_routing_pkg::pad_drive_t drive,
	input wire logic [7:0] ext,
	output logic [7:0] pad
);
	// an undriven pad shows the board level
	assign pad = (drive.out & drive.oe) | (ext & ~drive.oe);
endmodule

// ==== peripheral_pin_routing_checker.sv ====
`timescale 1ns/1ns
module peripheral_pin_routing_checker (
	input wire logic core_clk,
	input wire logic reset,
	input wire pin_routing_pkg::gpio_cfg_t gpio_u,
	input wire logic fault_protected_modulator_en,
	input wire logic [2:0] modulator_pair_en,
	input wire logic [5:0] fault_modulator_outputs,
	input wire logic sense_en,
	input wire logic spi_en,
	input wire logic spi_master,
	input wire logic spi_clock_out,
	input wire logic spi_miso_out,
	input wire logic uart_one_tx_en,
	input wire logic uart_one_transmit,
	input wire logic uart_zero_rx_en,
	input wire logic [7:0] port_read_q,
	input wire logic [2:0] current_sense_inputs,
	input wire pin_routing_pkg::pad_drive_t drive_p,
	input wire pin_routing_pkg::pad_drive_t drive_q,
	input wire pin_routing_pkg::pad_drive_t drive_s,
	input wire pin_routing_pkg::pad_drive_t drive_t,
	input wire pin_routing_pkg::pad_drive_t drive_u
);
	logic [1:0] run_q;
	logic [1:0] run_d;
	logic ok;
	// ok once three edges have passed since reset
	always_comb begin
		run_d = (run_q == 2'h3) ? run_q : run_q + 2'h1;
	end
	always_ff @(posedge core_clk) begin
		run_q <= reset ? 2'h0 : run_d;
	end
	assign ok = (run_q == 2'h3);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	a_reset_float:
	assert property (disable iff (1'b0) reset |=> (drive_p.oe | drive_q.oe
		| drive_s.oe | drive_t.oe | drive_u.oe) == 8'h00)
		else $error("pin driven in reset");
	a_top_gpio:
	assert property (ok |-> drive_u.oe[7:6] == $past(gpio_u.dir[7:6])
		&& (drive_u.out[7:6] & drive_u.oe[7:6])
		== $past(gpio_u.data[7:6] & gpio_u.dir[7:6]))
		else $error("top port U pins not general purpose");
	a_spi_master:
	assert property (ok && $past(spi_en && spi_master) |->
		drive_s.oe[6:4] == 3'h6 && drive_s.out[6] == $past(spi_clock_out))
		else $error("spi master pins wrong");
	a_spi_slave:
	assert property (ok && $past(spi_en && !spi_master) |->
		drive_s.oe[6:4] == 3'h1 && drive_s.out[4] == $past(spi_miso_out))
		else $error("spi slave pins wrong");
	a_uart_tx:
	assert property (ok && $past(uart_one_tx_en) |->
		drive_s.oe[3] && drive_s.out[3] == $past(uart_one_transmit))
		else $error("uart one transmit pin wrong");
	a_uart_rx:
	assert property (ok && $past(uart_zero_rx_en) |-> !drive_s.oe[0])
		else $error("uart zero receive pin driven");
	a_mod_pairs:
	assert property (ok && $past(fault_protected_modulator_en)
		&& $past(modulator_pair_en) == 3'h7 |-> drive_p.oe[5:0] == 6'h3F
		&& drive_p.out[5:0] == $past(fault_modulator_outputs))
		else $error("modulator pins wrong");
	a_sense_path:
	assert property (ok |-> current_sense_inputs ==
		($past(fault_protected_modulator_en && sense_en)
		? $past(port_read_q[6:4]) : 3'h7))
		else $error("current sense inputs wrong");
	c_spi_master: cover property (spi_en && spi_master);
	c_mod_all: cover property (modulator_pair_en == 3'h7);
	c_sense_low: cover property (current_sense_inputs != 3'h7);
endmodule

// ==== peripheral_pin_routing_test.sv ====
`timescale 1ns/1ns
bind peripheral_pin_routing peripheral_pin_routing_checker chk_u (.*);
module peripheral_pin_routing_test;
	logic core_clk, reset, fault_protected_modulator_en, sense_en, fault_en;
	logic spi_en, spi_master, spi_select_out, spi_select_oe, spi_clock_out;
	logic spi_mosi_out, spi_miso_out, uart_one_tx_en, uart_one_rx_en;
	logic uart_one_transmit, uart_zero_tx_en, uart_zero_rx_en;
	logic uart_zero_transmit, basic_modulator_en, spi_select_in;
	logic spi_clock_in, spi_mosi_in, spi_miso_in, uart_one_receive;
	logic uart_zero_receive;
	logic [2:0] modulator_pair_en, current_sense_inputs;
	logic [5:0] fault_modulator_outputs, basic_pin_en, basic_modulator_outputs;
	logic [3:0] pin_routing_select, fault_inputs, first_timer_channels;
	logic [3:0] second_timer_channels, third_timer_channels;
	logic [7:0] pad_in_p, pad_in_q, pad_in_s, pad_in_t, pad_in_u;
	logic [7:0] port_read_p, port_read_q, port_read_s, port_read_t;
	logic [7:0] port_read_u, ext_q, ext_s;
	pin_routing_pkg::gpio_cfg_t gpio_p, gpio_q, gpio_s, gpio_t, gpio_u;
	pin_routing_pkg::timer_io_t first_timer, second_timer, third_timer;
	pin_routing_pkg::pad_drive_t drive_p, drive_q, drive_s, drive_t, drive_u;
	int errors, check_count;
	peripheral_pin_routing dut_u (.*);
	pad_model pm_p (.drive(drive_p), .ext(8'h00), .pad(pad_in_p));
	pad_model pm_q (.drive(drive_q), .ext(ext_q), .pad(pad_in_q));
	pad_model pm_s (.drive(drive_s), .ext(ext_s), .pad(pad_in_s));
	pad_model pm_t (.drive(drive_t), .ext(8'h00), .pad(pad_in_t));
	pad_model pm_u (.drive(drive_u), .ext(8'h00), .pad(pad_in_u));
	always #25 core_clk = ~core_clk;
	task automatic ck(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// wait n edges, then let that edge's updates land
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		{core_clk, errors, check_count, ext_q, ext_s} = '0;
		reset = 1'b1;
		{gpio_p, gpio_q, gpio_s, gpio_t, gpio_u} = {5{16'hA5FF}};
		{fault_protected_modulator_en, sense_en, fault_en, spi_en, spi_master,
			spi_select_out, spi_select_oe, spi_clock_out, spi_mosi_out,
			spi_miso_out, uart_one_tx_en, uart_one_rx_en, uart_one_transmit,
			uart_zero_tx_en, uart_zero_rx_en, uart_zero_transmit,
			basic_modulator_en, modulator_pair_en, fault_modulator_outputs,
			basic_pin_en, basic_modulator_outputs, pin_routing_select,
			first_timer, second_timer, third_timer} = '0;
		wt(2);
		ck(drive_p.oe | drive_q.oe | drive_s.oe | drive_t.oe | drive_u.oe, 8'h00);
		@(posedge core_clk);
		reset <= 1'b0;
		#1;
		ck(drive_p.oe | drive_q.oe | drive_s.oe | drive_t.oe | drive_u.oe, 8'h00);
		wt(3);
		ck(drive_p.out & drive_p.oe, 8'hA5);
		ck(drive_u.oe, 8'hFF);
		$display("reset and gpio done");
		@(posedge core_clk);
		{fault_protected_modulator_en, modulator_pair_en} <= 4'hA;
		fault_modulator_outputs <= 6'h2C;
		wt(2);
		ck(drive_p.out, 8'hAD);
		ck(port_read_p, 8'hA5);
		@(posedge core_clk);
		modulator_pair_en <= 3'h7;
		gpio_q <= 16'hA57F;
		ext_q <= 8'h5A;
		{sense_en, fault_en} <= 2'h3;
		wt(7);
		ck(drive_p.out, 8'hAC);
		ck(current_sense_inputs, 3'h5);
		ck(fault_inputs, 4'hA);
		ck(port_read_q, 8'h5A);
		ck(drive_q.oe, 8'h00);
		@(posedge core_clk);
		fault_protected_modulator_en <= 1'b0;
		wt(2);
		ck(drive_p.out & drive_p.oe, 8'hA5);
		ck(drive_q.oe, 8'h7F);
		ck({current_sense_inputs, fault_inputs}, 7'h70);
		$display("modulator done");
		@(posedge core_clk);
		{spi_en, spi_master, spi_select_oe} <= 3'h7;
		{spi_select_out, spi_clock_out, spi_mosi_out, spi_miso_out} <= 4'h4;
		ext_s <= 8'h10;
		wt(7);
		ck(drive_s.oe, 8'hEF);
		ck(drive_s.out & 8'hE0, 8'h40);
		ck(spi_miso_in, 8'h01);
		@(posedge core_clk);
		{spi_master, spi_miso_out} <= 2'h1;
		ext_s <= 8'hA0;
		wt(7);
		ck(drive_s.oe, 8'h1F);
		ck(drive_s.out & 8'h10, 8'h10);
		ck({spi_select_in, spi_clock_in, spi_mosi_in}, 3'h5);
		$display("spi done");
		@(posedge core_clk);
		spi_en <= 1'b0;
		gpio_s <= 16'hFFFF;
		{uart_one_tx_en, uart_one_rx_en, uart_zero_tx_en, uart_zero_rx_en} <= 4'hF;
		ext_s <= 8'h00;
		wt(7);
		ck(drive_s.oe, 8'hFA);
		ck(drive_s.out & 8'h0A, 8'h00);
		ck({uart_one_receive, uart_zero_receive}, 2'h0);
		@(posedge core_clk);
		{uart_one_tx_en, uart_zero_rx_en} <= 2'h0;
		wt(2);
		ck(drive_s.oe, 8'hFB);
		ck(drive_s.out & 8'h08, 8'h08);
		ck(uart_zero_receive, 8'h01);
		$display("uart done");
		@(posedge core_clk);
		gpio_t <= 16'h0000;
		first_timer <= {1'b1, 4'hF, 4'h6, 4'h3};
		second_timer <= {1'b1, 4'hF, 4'h9, 4'hC};
		wt(2);
		ck(drive_t.oe, 8'hC3);
		ck(drive_t.out & 8'hC3, 8'h82);
		@(posedge core_clk);
		first_timer.enable <= 1'b0;
		wt(2);
		ck(drive_t.oe, 8'hC0);
		// let the pad level pass the synchroniser into the timer inputs
		wt(5);
		ck(port_read_t, 8'h80);
		ck(second_timer_channels, 4'h8);
		ck(first_timer_channels, 4'h0);
		$display("timer done");
		@(posedge core_clk);
		gpio_u <= 16'h80C0;
		{basic_modulator_en, basic_pin_en, basic_modulator_outputs} <= 13'h1F95;
		third_timer <= {1'b1, 4'hF, 4'hA, 4'hF};
		pin_routing_select <= 4'h3;
		wt(2);
		ck(drive_u.oe, 8'hFE);
		ck(drive_u.out, 8'h98);
		@(posedge core_clk);
		pin_routing_select <= 4'h0;
		basic_pin_en <= 6'h10;
		wt(2);
		ck(drive_u.oe, 8'hDF);
		ck(drive_u.out & 8'hDF, 8'h9A);
		wt(5);
		ck(port_read_u, 8'h9A);
		ck(third_timer_channels, 4'hA);
		$display("port u done");
		finish_test();
	end
endmodule
